// File: pkg/serial_port_pkg.sv
// Constants shared by the serial control port design files
package serial_port_pkg;
  // Frame layout: read/write indicator, address, data word, MSB first
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int FRAME_W = 1 + ADDR_W + DATA_W;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'(FRAME_W - 1);
  localparam logic [CNT_W-1:0] DATA_FIRST = 5'(1 + ADDR_W);
  // Register map
  localparam int NREGS = 16;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam int CAL_BIT = 15;
  localparam int CAL_CFG_W = 4;
  // Control register fields steered from the pins in pin mode
  localparam int DES_BIT = 7;
  localparam int TPM_BIT = 12;
  localparam int DPS_BIT = 14;
  localparam int PDQ_BIT = 10;
  localparam int PDI_BIT = 11;
endpackage : serial_port_pkg

// File: hw/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  // Reset to the idle levels so no false edge follows reset
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta <= IDLE;
      o_sync <= IDLE;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : pin_sync

// File: hw/serial_control_port.sv
// Serial control port with extended-control gating and register file
// What this block does
// - Enable low: serial registers override DES, TPM and DDR phase pins; power-down pins ORed with bits
// - Enable high: port off, registers at defaults
// - Select low: shift in and out on clock
// - Select high: ignore input, output released
// - Calibration pin ORed with control bit
`timescale 1ns/100ps
module serial_control_port
  import serial_port_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_extended_control_enable_n,
  input wire logic i_serial_select_n,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  input wire logic i_cal_pin,
  input wire logic i_des_pin,
  input wire logic i_tpm_pin,
  input wire logic i_ddr_phase_pin,
  input wire logic i_pdi_pin,
  input wire logic i_pdq_pin,
  output logic o_extended_control_mode,
  output logic o_des_mode,
  output logic o_test_pattern,
  output logic o_ddr_phase,
  output logic o_power_down_i,
  output logic o_power_down_q,
  output logic o_cal_start,
  output logic [DATA_W-1:0] o_ctrl_word
);
  localparam int NSYNC = 10;
  // Enable and select idle high, every other pin idles low
  localparam logic [NSYNC-1:0] PIN_IDLE = 10'h300;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] sync_pins;
  logic ext_en_n_s, sel_n_s, sclk_s, ser_in_s, cal_s;
  logic des_s, tpm_s, dps_s, pdi_s, pdq_s;
  logic sclk_prev;
  logic [CNT_W-1:0] bit_cnt;
  logic [FRAME_W-1:0] shift_in;
  logic [DATA_W-1:0] shift_out;
  logic is_read;
  logic [DATA_W-1:0] regs [NREGS];
  logic cal_req_prev;
  logic cal_armed;

  assign raw_pins = {i_extended_control_enable_n, i_serial_select_n, i_sclk,
    i_serial_in, i_cal_pin, i_des_pin, i_tpm_pin, i_ddr_phase_pin,
    i_pdi_pin, i_pdq_pin};

  // All pins pass two flops before use
  pin_sync #(.WIDTH(NSYNC), .IDLE(PIN_IDLE)) u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(raw_pins),
    .o_sync(sync_pins)
  );

  assign {ext_en_n_s, sel_n_s, sclk_s, ser_in_s, cal_s, des_s, tpm_s, dps_s,
    pdi_s, pdq_s} = sync_pins;

  // Mode decode and serial clock edges
  wire ext_mode = !ext_en_n_s;
  wire active = ext_mode && !sel_n_s;
  wire sclk_rise = sclk_s && !sclk_prev;
  wire sclk_fall = !sclk_s && sclk_prev;
  wire [FRAME_W-1:0] next_frame = {shift_in[FRAME_W-2:0], ser_in_s};
  wire frame_done = active && sclk_rise && (bit_cnt == LAST_BIT);
  wire addr_done = active && sclk_rise && (bit_cnt == DATA_FIRST - 5'h1);
  wire [ADDR_W-1:0] rd_addr = next_frame[ADDR_W-1:0];
  // Address sits just below the read/write bit after twenty edges
  wire [ADDR_W-1:0] wr_addr = shift_in[FRAME_W-3 -: ADDR_W];
  wire [DATA_W-1:0] ctrl = regs[CTRL_ADDR];

  // Serial clock edge tracking; the host may park it low
  // Parked clock tolerated
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  // Frame shifter: rising edges capture, count bits within a select
  // Shift on clock
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      bit_cnt <= '0;
      shift_in <= '0;
      is_read <= 1'b0;
    end else if (!active) begin
      bit_cnt <= '0;
      is_read <= 1'b0;
    end else if (sclk_rise && bit_cnt <= LAST_BIT) begin
      shift_in <= next_frame;
      bit_cnt <= bit_cnt + 5'h1;
      if (bit_cnt == '0) begin
        is_read <= ser_in_s;
      end
    end
  end

  // Read data launched on falling edges after the address
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      shift_out <= '0;
    end else if (!active) begin
      shift_out <= '0;
    end else if (addr_done) begin
      shift_out <= regs[rd_addr];
    end else if (sclk_fall && bit_cnt > DATA_FIRST) begin
      shift_out <= {shift_out[DATA_W-2:0], 1'b0};
    end
  end

  // Serial output driven only while selected in extended mode
  // Output released when deselected
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_serial_out <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      o_serial_out <= active ? shift_out[DATA_W-1] : 1'b0;
      o_serial_out_oe <= active;
    end
  end

  // Register file; held at defaults while extended mode is off
  // Defaults in pin mode
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < NREGS; k++) begin
        regs[k] <= (k == 0) ? CTRL_RESET : REG_RESET;
      end
    end else if (!ext_mode) begin
      for (int k = 0; k < NREGS; k++) begin
        regs[k] <= (k == 0) ? CTRL_RESET : REG_RESET;
      end
    end else if (frame_done && !is_read) begin
      regs[wr_addr] <= next_frame[DATA_W-1:0];
    end
  end

  // Mode outputs: pins in pin mode, control register in extended mode; power-down is pin OR bit there
  // Register control selected
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_extended_control_mode <= 1'b0;
      o_des_mode <= 1'b0;
      o_test_pattern <= 1'b0;
      o_ddr_phase <= 1'b0;
      o_power_down_i <= 1'b0;
      o_power_down_q <= 1'b0;
      o_ctrl_word <= CTRL_RESET;
    end else begin
      o_extended_control_mode <= ext_mode;
      o_des_mode <= ext_mode ? ctrl[DES_BIT] : des_s;
      o_test_pattern <= ext_mode ? ctrl[TPM_BIT] : tpm_s;
      o_ddr_phase <= ext_mode ? ctrl[DPS_BIT] : dps_s;
      o_power_down_i <= pdi_s || (ext_mode && ctrl[PDI_BIT]);
      o_power_down_q <= pdq_s || (ext_mode && ctrl[PDQ_BIT]);
      o_ctrl_word <= ctrl;
    end
  end

  // Calibration request: pin OR bit, armed once both are low
  // Calibration OR
  wire cal_req = cal_s || (ext_mode && ctrl[CAL_BIT]);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cal_req_prev <= 1'b1;
      cal_armed <= 1'b0;
      o_cal_start <= 1'b0;
    end else begin
      cal_req_prev <= cal_req;
      o_cal_start <= cal_armed && cal_req && !cal_req_prev;
      if (!cal_req) begin
        cal_armed <= 1'b1;
      end else if (!cal_req_prev && cal_armed) begin
        cal_armed <= 1'b0;
      end
    end
  end

  a_out_release: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (sel_n_s || ext_en_n_s) |=> !o_serial_out_oe) else
    $error("serial output driven while deselected");

  a_regs_default: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    ext_en_n_s |=> (regs[CTRL_ADDR] == CTRL_RESET)) else
    $error("control register not at default in pin mode");

  a_pin_mode_des: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    ext_en_n_s |=> (o_des_mode == $past(des_s))) else
    $error("mode output ignores pin in pin mode");

  a_cnt_clear: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    !active |=> (bit_cnt == '0)) else
    $error("bit counter not cleared");

  // Calibration start needs a rising request
  a_cal_edge: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_cal_start |-> $past(cal_req) && !$past(cal_req, 2)) else
    $error("calibration start without rising request");

  a_write_lands: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (frame_done && !is_read && ext_mode) |=>
    (regs[$past(wr_addr)] == $past(next_frame[DATA_W-1:0]))) else
    $error("write frame not stored");

  a_ext_flag: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    !ext_en_n_s [*2] |-> o_extended_control_mode) else
    $error("extended mode flag wrong");

  a_park_hold: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (active && !sclk_s && !sclk_prev) |=> $stable(bit_cnt)) else
    $error("bit count moved with clock parked");
endmodule : serial_control_port

// File: tb/spi_host_model.sv
// Host serial master model that frames accesses to the port
`timescale 1ns/100ps
module spi_host_model (
  input wire logic i_mclk,
  input wire logic i_serial_out,
  output logic o_sclk,
  output logic o_serial_select_n,
  output logic o_serial_in
);
  logic [20:0] seen;
  // Idle bus: deselected, clock parked low
  initial begin
    o_sclk = 1'b0;
    o_serial_select_n = 1'b1;
    o_serial_in = 1'b0;
  end
  // One full frame; half is the clock half period in mclk cycles
  // rw, address, data MSB first
  task automatic xfer(input logic [20:0] f, input int half,
                      output logic [15:0] rdata);
    o_serial_select_n <= 1'b0;
    for (int i = 20; i >= 0; i--) begin
      o_serial_in <= f[i];
      repeat (half) @(posedge i_mclk);
      // Sample data out as the clock rises
      seen[i] = i_serial_out;
      o_sclk <= 1'b1;
      repeat (half) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    repeat (half) @(posedge i_mclk);
    // Clock parked low; data line no longer held
    o_serial_select_n <= 1'b1;
    o_serial_in <= ~f[0];
    repeat (half) @(posedge i_mclk);
    rdata = seen[15:0];
  endtask : xfer
endmodule : spi_host_model

// File: tb/tb_top.sv
// Self-checking bench for the serial control port
`timescale 1ns/100ps
module tb_top
  import serial_port_pkg::*;
();
  logic i_mclk, i_reset, ext_en_n, sel_n, sclk, ser_in, ser_out, ser_out_oe;
  logic cal, des, tpm, ddr, pdi, pdq;
  logic ext_mode_o, des_o, tpm_o, ddr_o, pdi_o, pdq_o, cal_o;
  logic [DATA_W-1:0] ctrl, rd;
  int failures = 0;
  int samples_checked = 0;
  int cal_seen = 0;
  int n;
  int oe_cnt = 0;

  serial_control_port dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_extended_control_enable_n(ext_en_n), .i_serial_select_n(sel_n),
    .i_sclk(sclk), .i_serial_in(ser_in), .o_serial_out(ser_out),
    .o_serial_out_oe(ser_out_oe), .i_cal_pin(cal), .i_des_pin(des),
    .i_tpm_pin(tpm), .i_ddr_phase_pin(ddr), .i_pdi_pin(pdi),
    .i_pdq_pin(pdq), .o_extended_control_mode(ext_mode_o),
    .o_des_mode(des_o),
    .o_test_pattern(tpm_o), .o_ddr_phase(ddr_o), .o_power_down_i(pdi_o),
    .o_power_down_q(pdq_o), .o_cal_start(cal_o), .o_ctrl_word(ctrl));
  spi_host_model host (.i_mclk(i_mclk), .i_serial_out(ser_out),
    .o_sclk(sclk), .o_serial_select_n(sel_n), .o_serial_in(ser_in));

  // Clock and calibration pulse counter
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) if (cal_o === 1'b1) cal_seen++;
  // Cycles in which the serial output is driven
  always @(posedge i_mclk) if (ser_out_oe === 1'b1) oe_cnt++;

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.xfer({1'b0, a, d}, 10, rd);
    repeat (6) @(posedge i_mclk);
  endtask : wr
  task automatic pause();
    repeat (10) @(posedge i_mclk);
  endtask : pause
  function automatic logic [15:0] modes();
    return {10'h000, ext_mode_o, des_o, tpm_o, ddr_o, pdi_o, pdq_o};
  endfunction : modes

  // Pin mode: writes refused, outputs follow pins
  task automatic pin_mode();
    {des, tpm, ddr, pdi, pdq} <= 5'h1D;
    wr(CTRL_ADDR, 16'hFFFF);
    pause();
    check("pin modes", 16'h001D, modes()); // pins steer
    check("ctrl word", 16'h0000, ctrl); // write ignored
    check("out enable", 16'h0000, {15'h0000, ser_out_oe}); // off
  endtask : pin_mode
  // Extended mode: register overrides DES/TPM/DDR pins, write and read back
  task automatic ext_mode();
    ext_en_n <= 1'b0;
    pause();
    wr(CTRL_ADDR, 16'h0800);
    check("ctrl word", 16'h0800, ctrl); // register
    check("ext modes", 16'h0023, modes()); // des, tpm, ddr pins ignored; pdq pin still ORed in
    wr(4'h5, 16'hA5C3);
    n = oe_cnt;
    host.xfer({1'b1, 4'h5, 16'h0000}, 10, rd);
    check("read back", 16'hA5C3, rd); // shifted data
    // Driven for at least 21 bits of 20 cycles each
    check("oe driven", 16'h0001, {15'h0000, (oe_cnt - n) >= 420});
    pause();
    check("out enable", 16'h0000, {15'h0000, ser_out_oe});
  endtask : ext_mode
  // Leaving extended mode resets every register
  task automatic disable_port();
    ext_en_n <= 1'b1;
    pause();
    check("ctrl word", 16'h0000, ctrl); // defaults
    ext_en_n <= 1'b0;
    pause();
    host.xfer({1'b1, 4'h5, 16'h0000}, 10, rd);
    check("reset reg", 16'h0000, rd); // defaults
  endtask : disable_port
  // Calibration request from pin or control bit
  task automatic calib();
    n = cal_seen;
    cal <= 1'b1;
    pause();
    wr(CTRL_ADDR, 16'h8000);
    check("cal pulses", 16'h0001, 16'(cal_seen - n)); // pin only
    cal <= 1'b0;
    wr(CTRL_ADDR, 16'h0000);
    wr(CTRL_ADDR, 16'h8000);
    pause();
    check("cal pulses", 16'h0002, 16'(cal_seen - n)); // bit
  endtask : calib

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    i_reset = 1'b1;
    ext_en_n = 1'b1;
    {cal, des, tpm, ddr, pdi, pdq} = 6'h00;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    pause();
    pin_mode();
    ext_mode();
    disable_port();
    calib();
    report_and_stop();
  end
  // Watchdog for a hung run
  initial begin
    #100us;
    failures++;
    report_and_stop();
  end
endmodule : tb_top
